// File: hw/ncmp_host.v
`default_nettype none
`include "ncmp_regs.vh"
// Operation
// - current-page result valid only when page buffer ready.
// - previous-page result valid only when data cache ready.
// - host restarts multi cached program when block address changes.
// - full block: 64 pages, end with second load then final command.
// - paired blocks must lie in the same half of block range.
// - one block per district, same page bits in both.
// - host ends multi cached program with final command.
// - only sequence commands, status read and reset during sequence.
// - all copy pages stay within one district.
// - copy data input optional; only altered bytes are written.
// - write protect held high during copy; end with copy-load then final.
// - multi copy uses same page bits, restarts on block change.
module ncmp_host (
    input  wire        clock,
    input  wire        rst_b,
    input  wire        op_valid,
    input  wire [2:0]  op_code,
    input  wire [23:0] op_row_a,
    input  wire [23:0] op_row_b,
    input  wire [15:0] op_col,
    input  wire [12:0] op_len,
    input  wire        buf_wr_en,
    input  wire [12:0] buf_wr_addr,
    input  wire [7:0]  buf_wr_data,
    input  wire [7:0]  data_lines_in,
    input  wire        ready_busy_pin,
    output reg         op_ready,
    output reg         op_done,
    output reg         op_error,
    output reg  [7:0]  stat_byte,
    output reg  [7:0]  data_lines_out,
    output reg         data_lines_oe_n,
    output reg         cmd_latch,
    output reg         addr_latch,
    output reg         chip_enable_n,
    output reg         write_strobe_n,
    output reg         read_strobe_n,
    output reg         write_protect_n
);
    // ==========================================
    // states
    localparam S_IDLE  = 4'h0;
    localparam S_CMD   = 4'h1;
    localparam S_ADDR  = 4'h2;
    localparam S_DATA  = 4'h3;
    localparam S_WAIT  = 4'h4;
    localparam S_RDST  = 4'h5;
    localparam S_NEXT  = 4'h6;
    localparam S_DONE  = 4'h7;
    localparam S_SRD   = 4'h8;

    // ==========================================
    // pin synchronisers
    reg  [7:0] dl_s1_reg, dl_s2_reg;
    reg        rb_s1_reg, rb_s2_reg;
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            dl_s1_reg <= `NCMP_ZERO8;
            dl_s2_reg <= `NCMP_ZERO8;
            rb_s1_reg <= 1'b0;
            rb_s2_reg <= 1'b0;
        end else begin
            dl_s1_reg <= data_lines_in;
            dl_s2_reg <= dl_s1_reg;
            rb_s1_reg <= ready_busy_pin;
            rb_s2_reg <= rb_s1_reg;
        end
    end

    // block address and half checks for two-district pairs
    function pair_ok;
        input [23:0] ra;
        input [23:0] rb;
        begin
            pair_ok = (ra[6] != rb[6]) &&
                      (ra[6+`NCMP_HALF_BLK_BIT] == rb[6+`NCMP_HALF_BLK_BIT]) &&
                      (ra[5:0] == rb[5:0]);
        end
    endfunction

    // ==========================================
    // sequence program: list of steps per operation
    // step kinds: 0 cmd, 1 addr row a, 2 data, 3 wait rb, 4 status read, 5 end
    // 6 addr row b
    reg [3:0]  state_reg;
    reg [2:0]  op_reg;
    reg [3:0]  step_reg;
    reg [23:0] row_a_reg, row_b_reg;
    reg [15:0] col_reg;
    reg [12:0] len_reg;
    reg [12:0] cnt_reg;
    reg [3:0]  tmr_reg;
    reg [2:0]  acyc_reg;
    reg [7:0]  cur_cmd;
    reg [2:0]  cur_kind;
    wire [7:0] mem_q;

    ncmp_page_mem u_mem (
        .clock   (clock),
        .wr_en   (buf_wr_en),
        .wr_addr (buf_wr_addr),
        .wr_data (buf_wr_data),
        .rd_addr (cnt_reg),
        .rd_data (mem_q)
    );

    // step table
    always @* begin
        cur_cmd  = `NCMP_ZERO8;
        cur_kind = 3'd5;
        case (op_reg)
        `NCMP_OP_PROG_CACHE, `NCMP_OP_PROG_FINAL: begin
            case (step_reg)
            4'd0: begin cur_kind = 3'd0; cur_cmd = `NCMP_CMD_LOAD; end
            4'd1: cur_kind = 3'd1;
            4'd2: cur_kind = 3'd2;
            4'd3: begin
                cur_kind = 3'd0;
                cur_cmd  = (op_reg == `NCMP_OP_PROG_CACHE) ? `NCMP_CMD_CACHE
                                                           : `NCMP_CMD_FINAL;
            end
            4'd4: cur_kind = 3'd3;
            4'd5: begin cur_kind = 3'd0; cur_cmd = `NCMP_CMD_STATUS; end
            4'd6: cur_kind = 3'd4;
            default: cur_kind = 3'd5;
            endcase
        end
        `NCMP_OP_MULTI_CACHE, `NCMP_OP_MULTI_FINAL: begin
            case (step_reg)
            4'd0: begin cur_kind = 3'd0; cur_cmd = `NCMP_CMD_LOAD; end
            4'd1: cur_kind = 3'd1;
            4'd2: cur_kind = 3'd2;
            4'd3: begin cur_kind = 3'd0; cur_cmd = `NCMP_CMD_DUMMY; end
            4'd4: cur_kind = 3'd3;
            4'd5: begin cur_kind = 3'd0; cur_cmd = `NCMP_CMD_LOAD2; end
            4'd6: cur_kind = 3'd6;
            4'd7: cur_kind = 3'd2;
            4'd8: begin
                cur_kind = 3'd0;
                cur_cmd  = (op_reg == `NCMP_OP_MULTI_CACHE) ? `NCMP_CMD_CACHE
                                                            : `NCMP_CMD_FINAL;
            end
            4'd9: cur_kind = 3'd3;
            4'd10: begin cur_kind = 3'd0; cur_cmd = `NCMP_CMD_XSTATUS; end
            4'd11: cur_kind = 3'd4;
            default: cur_kind = 3'd5;
            endcase
        end
        `NCMP_OP_STATUS, `NCMP_OP_XSTATUS: begin
            case (step_reg)
            4'd0: begin
                cur_kind = 3'd0;
                cur_cmd  = (op_reg == `NCMP_OP_STATUS) ? `NCMP_CMD_STATUS
                                                       : `NCMP_CMD_XSTATUS;
            end
            4'd1: cur_kind = 3'd4;
            default: cur_kind = 3'd5;
            endcase
        end
        default: begin
            // cached or final copy: copy-load target, optional data, program
            case (step_reg)
            4'd0: begin cur_kind = 3'd0; cur_cmd = `NCMP_CMD_COPYLD; end
            4'd1: cur_kind = 3'd1;
            4'd2: cur_kind = 3'd2;
            4'd3: begin
                cur_kind = 3'd0;
                cur_cmd  = (op_reg == `NCMP_OP_COPY_CACHE) ? `NCMP_CMD_CACHE
                                                           : `NCMP_CMD_FINAL;
            end
            4'd4: cur_kind = 3'd3;
            4'd5: begin cur_kind = 3'd0; cur_cmd = `NCMP_CMD_STATUS; end
            4'd6: cur_kind = 3'd4;
            default: cur_kind = 3'd5;
            endcase
        end
        endcase
    end

    // address byte selection: two column then three row bytes
    wire [23:0] row_sel = (cur_kind == 3'd6) ? row_b_reg : row_a_reg;
    reg  [7:0]  addr_byte;
    always @* begin
        case (acyc_reg)
        3'd0:    addr_byte = col_reg[7:0];
        3'd1:    addr_byte = col_reg[15:8];
        3'd2:    addr_byte = row_sel[7:0];
        3'd3:    addr_byte = row_sel[15:8];
        default: addr_byte = row_sel[23:16];
        endcase
    end

    // ==========================================
    // main sequencer; one strobe per byte, low then high phase
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_reg       <= S_IDLE;
            op_reg          <= 3'h0;
            step_reg        <= 4'h0;
            row_a_reg       <= 24'h000000;
            row_b_reg       <= 24'h000000;
            col_reg         <= 16'h0000;
            len_reg         <= 13'h0000;
            cnt_reg         <= 13'h0000;
            tmr_reg         <= 4'h0;
            acyc_reg        <= 3'h0;
            op_ready        <= 1'b0;
            op_done         <= 1'b0;
            op_error        <= 1'b0;
            stat_byte       <= `NCMP_ZERO8;
            data_lines_out  <= `NCMP_ZERO8;
            data_lines_oe_n <= 1'b1;
            cmd_latch       <= 1'b0;
            addr_latch      <= 1'b0;
            chip_enable_n   <= 1'b1;
            write_strobe_n  <= 1'b1;
            read_strobe_n   <= 1'b1;
            write_protect_n <= 1'b0;
        end else begin
            op_done <= 1'b0;
            case (state_reg)
            S_IDLE: begin
                op_ready        <= 1'b1;
                chip_enable_n   <= 1'b1;
                data_lines_oe_n <= 1'b1;
                if (op_valid && op_ready) begin
                    op_ready  <= 1'b0;
                    op_reg    <= op_code;
                    row_a_reg <= op_row_a;
                    row_b_reg <= op_row_b;
                    col_reg   <= op_col;
                    len_reg   <= op_len;
                    step_reg  <= 4'h0;
                    op_error  <= 1'b0;
                    write_protect_n <= 1'b1;
                    if ((op_code == `NCMP_OP_MULTI_CACHE ||
                         op_code == `NCMP_OP_MULTI_FINAL) &&
                        !pair_ok(op_row_a, op_row_b)) begin
                        op_error <= 1'b1;
                        state_reg <= S_DONE;
                    end else begin
                        state_reg <= S_NEXT;
                    end
                end
            end
            S_NEXT: begin
                chip_enable_n <= 1'b0;
                cnt_reg  <= 13'h0000;
                acyc_reg <= 3'h0;
                tmr_reg  <= 4'h0;
                case (cur_kind)
                3'd0: begin
                    cmd_latch <= 1'b1;
                    data_lines_out  <= cur_cmd;
                    data_lines_oe_n <= 1'b0;
                    state_reg <= S_CMD;
                end
                3'd1, 3'd6: begin
                    addr_latch <= 1'b1;
                    data_lines_oe_n <= 1'b0;
                    state_reg <= S_ADDR;
                end
                3'd2: state_reg <= (len_reg == 13'h0000) ? S_WAIT : S_DATA;
                3'd3: state_reg <= S_WAIT;
                3'd4: begin
                    data_lines_oe_n <= 1'b1;
                    state_reg <= S_RDST;
                end
                default: state_reg <= S_DONE;
                endcase
                if (cur_kind == 3'd2 && len_reg == 13'h0000) begin
                    step_reg <= step_reg + 4'h1;
                    state_reg <= S_NEXT;
                end
            end
            S_CMD, S_ADDR, S_DATA: begin
                tmr_reg <= tmr_reg + 4'h1;
                if (state_reg == S_ADDR) begin
                    data_lines_out <= addr_byte;
                end else if (state_reg == S_DATA) begin
                    data_lines_out  <= mem_q;
                    data_lines_oe_n <= 1'b0;
                end
                write_strobe_n <= (tmr_reg < `NCMP_CYC_SETUP) ? 1'b0 : 1'b1;
                if (tmr_reg == `NCMP_CYC_SETUP + `NCMP_CYC_HOLD) begin
                    tmr_reg <= 4'h0;
                    if (state_reg == S_ADDR &&
                        acyc_reg != `NCMP_ADDR_CYCLES - 3'd1) begin
                        acyc_reg <= acyc_reg + 3'd1;
                    end else if (state_reg == S_DATA &&
                                 cnt_reg != len_reg - 13'h0001) begin
                        cnt_reg <= cnt_reg + 13'h0001;
                    end else begin
                        cmd_latch  <= 1'b0;
                        addr_latch <= 1'b0;
                        step_reg   <= step_reg + 4'h1;
                        state_reg  <= S_NEXT;
                    end
                end
            end
            S_WAIT: begin
                // wait NCMP_CYC_RB_WAIT cycles for busy to show, then for ready
                data_lines_oe_n <= 1'b1;
                if (tmr_reg != `NCMP_CYC_RB_WAIT) begin
                    tmr_reg <= tmr_reg + 4'h1;
                end else if (rb_s2_reg) begin
                    step_reg  <= step_reg + 4'h1;
                    state_reg <= S_NEXT;
                end
            end
            S_RDST: begin
                tmr_reg <= tmr_reg + 4'h1;
                read_strobe_n <= (tmr_reg < `NCMP_CYC_HOLD) ? 1'b0 : 1'b1;
                if (tmr_reg == `NCMP_CYC_HOLD + 4'h2) begin
                    stat_byte <= dl_s2_reg;
                    state_reg <= S_SRD;
                end
            end
            S_SRD: begin
                // bit 0 only trusted with buffer ready, bit 1 with cache ready
                if (dl_s2_reg[`NCMP_ST_PB_RDY] && stat_byte[`NCMP_ST_CUR]) begin
                    op_error <= 1'b1;
                end
                if (dl_s2_reg[`NCMP_ST_DC_RDY] && stat_byte[`NCMP_ST_PREV]) begin
                    op_error <= 1'b1;
                end
                step_reg  <= step_reg + 4'h1;
                state_reg <= S_NEXT;
            end
            default: begin
                // S_DONE
                chip_enable_n   <= 1'b1;
                data_lines_oe_n <= 1'b1;
                op_done   <= 1'b1;
                state_reg <= S_IDLE;
            end
            endcase
        end
    end
endmodule
`default_nettype wire

// File: hw/ncmp_page_mem.v
`default_nettype none
`include "ncmp_regs.vh"
// page data held for loading, registered read
module ncmp_page_mem (
    input  wire        clock,
    input  wire        wr_en,
    input  wire [12:0] wr_addr,
    input  wire [7:0]  wr_data,
    input  wire [12:0] rd_addr,
    output reg  [7:0]  rd_data
);
    reg [7:0] mem [0:`NCMP_BUF_DEPTH-13'd1];
    // ==========================================
    // write and registered read
    always @(posedge clock) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule
`default_nettype wire

// File: hw/ncmp_regs.vh
`ifndef NCMP_REGS_VH
`define NCMP_REGS_VH
// ==========================================
// command codes
`define NCMP_CMD_LOAD        8'h80
`define NCMP_CMD_LOAD2       8'h81
`define NCMP_CMD_DUMMY       8'h11
`define NCMP_CMD_CACHE       8'h15
`define NCMP_CMD_FINAL       8'h10
`define NCMP_CMD_STATUS      8'h70
`define NCMP_CMD_XSTATUS     8'h71
`define NCMP_CMD_COPYLD      8'h8C
`define NCMP_CMD_READ0       8'h00
`define NCMP_CMD_READ1       8'h30
`define NCMP_CMD_RESET       8'hFF
// ==========================================
// operation codes on the user port
`define NCMP_OP_PROG_CACHE   3'h0
`define NCMP_OP_PROG_FINAL   3'h1
`define NCMP_OP_MULTI_CACHE  3'h2
`define NCMP_OP_MULTI_FINAL  3'h3
`define NCMP_OP_STATUS       3'h4
`define NCMP_OP_XSTATUS      3'h5
`define NCMP_OP_COPY_CACHE   3'h6
`define NCMP_OP_COPY_FINAL   3'h7
// ==========================================
// status bit positions
`define NCMP_ST_CUR          0
`define NCMP_ST_PREV         1
`define NCMP_ST_D0S1         1
`define NCMP_ST_D1S1         2
`define NCMP_ST_D0S2         3
`define NCMP_ST_D1S2         4
`define NCMP_ST_PB_RDY       5
`define NCMP_ST_DC_RDY       6
`define NCMP_ST_NOT_WP       7
// ==========================================
// geometry and timing
`define NCMP_PAGES_PER_BLK   7'd64
`define NCMP_HALF_BLK_BIT    11
`define NCMP_ADDR_CYCLES     3'd5
`define NCMP_BUF_DEPTH       13'd4352
`define NCMP_CYC_SETUP       4'd4
`define NCMP_CYC_HOLD        4'd4
`define NCMP_CYC_RB_WAIT     4'd8
`define NCMP_ZERO8           8'h00
`endif

// File: sim/ncmp_dev_model.sv
`default_nettype none
`include "ncmp_regs.vh"
// ==========================================
// flash device seen by the host
module ncmp_dev_model (
    input  wire logic       clock,
    input  wire logic [7:0] bus,
    input  wire logic       cmd_latch,
    input  wire logic       addr_latch,
    input  wire logic       chip_enable_n,
    input  wire logic       write_strobe_n,
    input  wire logic       read_strobe_n,
    input  wire logic       write_protect_n,
    input  wire logic [3:0] inj_fail,
    input  wire logic [5:0] busy_cyc,
    output var  logic       ready_busy_pin,
    output var  logic [7:0] dev_q
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] cmd_log[$];
    logic [7:0] adr_log[$];
    logic [7:0] dat_log[$];
    logic [7:0] last_cmd = 8'h00;
    logic [3:0] dist_fail = 4'h0;
    logic [1:0] pg_fail = 2'h0;
    logic       hold = 1'h0;
    logic [7:0] st;
    initial ready_busy_pin = 1'h1;
    // busy for some clocks, program and verify folded in
    task automatic busy(input logic [5:0] n);
        ready_busy_pin = 1'h0;
        fork
            begin
                repeat (n) @(posedge clock);
                ready_busy_pin = 1'h1;
            end
        join_none
    endtask
    // latch command, address or data as the write strobe rises
    always @(posedge write_strobe_n) begin
        if (!chip_enable_n && cmd_latch) begin
            cmd_log.push_back(bus);
            last_cmd = bus;
            if (bus == `NCMP_CMD_CACHE || bus == `NCMP_CMD_FINAL) begin
                pg_fail = {pg_fail[0], inj_fail[0]};
                dist_fail = inj_fail;
                busy(busy_cyc);
            end else if (bus == `NCMP_CMD_DUMMY) begin
                busy(6'h02);
            end
        end else if (!chip_enable_n && addr_latch) begin
            adr_log.push_back(bus);
        end else if (!chip_enable_n) begin
            dat_log.push_back(bus);
        end
    end
    // status stands from read strobe fall until next write or deselect
    always @(negedge read_strobe_n or negedge write_strobe_n or posedge chip_enable_n)
        hold = !read_strobe_n && !chip_enable_n;
    // status byte of the last status command, inverse when released
    always_comb begin
        if (last_cmd == `NCMP_CMD_XSTATUS)
            st = {write_protect_n, {2{ready_busy_pin}}, dist_fail, |dist_fail[1:0]};
        else
            st = {write_protect_n, {2{ready_busy_pin}}, 3'h0, pg_fail};
        dev_q = hold ? st : ~st;
    end
endmodule
`default_nettype wire

// File: sim/ncmp_host_chk.sv
`default_nettype none
`include "ncmp_regs.vh"
// ==========================================
// host sequencing checks
module ncmp_host_chk (
    input wire logic        clock,
    input wire logic        rst_b,
    input wire logic        op_valid,
    input wire logic [2:0]  op_code,
    input wire logic [23:0] op_row_a,
    input wire logic [23:0] op_row_b,
    input wire logic        op_ready,
    input wire logic        op_done,
    input wire logic        op_error,
    input wire logic [7:0]  stat_byte,
    input wire logic [7:0]  data_lines_out,
    input wire logic        data_lines_oe_n,
    input wire logic        cmd_latch,
    input wire logic        addr_latch,
    input wire logic        chip_enable_n,
    input wire logic        write_strobe_n,
    input wire logic        read_strobe_n,
    input wire logic        write_protect_n
);
    timeunit 1ns;
    timeprecision 100ps;
    logic bad;
    // multi request naming an illegal district pair
    assign bad = op_valid && op_ready && op_code[2:1] == 2'h1
        && (op_row_a[6] == op_row_b[6] || op_row_a[17] != op_row_b[17]
        || op_row_a[5:0] != op_row_b[5:0]);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    a_done_pulse: assert property (op_done |=> !op_done)
        else $error("done longer than one cycle");
    a_ready_back: assert property (op_done |=> op_ready)
        else $error("not idle after done");
    a_take_busy: assert property (op_valid && op_ready |=> !op_ready)
        else $error("still idle after take");
    a_pair_error: assert property (bad |-> ##[1:2] (op_done && op_error))
        else $error("bad pair not flagged");
    a_pair_quiet: assert property (bad |=> chip_enable_n[*2])
        else $error("bad pair reached pins");
    a_write_four: assert property ($fell(write_strobe_n)
        |=> !write_strobe_n[*3] ##1 write_strobe_n)
        else $error("write strobe width");
    a_read_four: assert property ($fell(read_strobe_n) |=> !read_strobe_n[*3] ##1 read_strobe_n)
        else $error("read strobe width");
    a_read_release: assert property (!read_strobe_n |-> data_lines_oe_n)
        else $error("host drives during read");
    a_latch_apart: assert property (!(cmd_latch && addr_latch))
        else $error("both latches high");
    a_status_holds: assert property (op_ready && !op_valid
        |=> $stable(stat_byte) && $stable(op_error))
        else $error("status changed while idle");
    a_copy_wp: assert property (cmd_latch && !write_strobe_n
        && data_lines_out == `NCMP_CMD_COPYLD |-> write_protect_n)
        else $error("copy with write protect");
    c_bad: cover property (bad);
    c_fail: cover property (op_done && op_error);
    c_copy: cover property (op_valid && op_ready && op_code == 3'h7);
endmodule
bind ncmp_host ncmp_host_chk i_chk (.clock, .rst_b, .op_valid, .op_code, .op_row_a, .op_row_b,
    .op_ready, .op_done, .op_error, .stat_byte, .data_lines_out, .data_lines_oe_n, .cmd_latch,
    .addr_latch, .chip_enable_n, .write_strobe_n, .read_strobe_n, .write_protect_n);
`default_nettype wire

// File: sim/tb_nand_cache_multi_district_program.sv
`default_nettype none
`include "ncmp_regs.vh"
// ==========================================
// bench for the flash host sequencer
module tb_nand_cache_multi_district_program;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int LIMIT = 60000;
    logic        clock = 1'h0;
    logic        rst_b = 1'h0;
    logic        op_valid = 1'h0;
    logic [2:0]  op_code = 3'h0;
    logic [23:0] op_row_a = 24'h000000;
    logic [23:0] op_row_b = 24'h000000;
    logic [15:0] op_col = 16'h0000;
    logic [12:0] op_len = 13'h0000;
    logic        buf_wr_en = 1'h0;
    logic [12:0] buf_wr_addr = 13'h0000;
    logic [7:0]  buf_wr_data = 8'h00;
    logic [3:0]  inj = 4'h0;
    logic [5:0]  busy_cyc = 6'h01;
    wire  [7:0]  bus, dq, dout, stat_byte;
    wire         rb, op_ready, op_done, op_error, oe_n, cle, ale, ce_n, we_n, re_n, wp_n;
    logic [7:0]  mem[16];
    logic [1:0]  t_pg = 2'h0;
    logic [3:0]  t_dist = 4'h0;
    int          n_mismatch = 0;
    int          checked = 0;
    int          cyc = 0;
    always #2.5 clock = ~clock;
    // shared data lines: host drives while its enable is low
    assign bus = !oe_n ? dout : dq;
    ncmp_host i_ncmp_host (
        .clock, .rst_b, .op_valid, .op_code, .op_row_a, .op_row_b, .op_col, .op_len,
        .buf_wr_en, .buf_wr_addr, .buf_wr_data, .data_lines_in(bus), .ready_busy_pin(rb),
        .op_ready, .op_done, .op_error, .stat_byte, .data_lines_out(dout),
        .data_lines_oe_n(oe_n), .cmd_latch(cle), .addr_latch(ale), .chip_enable_n(ce_n),
        .write_strobe_n(we_n), .read_strobe_n(re_n), .write_protect_n(wp_n));
    ncmp_dev_model i_ncmp_dev_model (
        .clock, .bus, .cmd_latch(cle), .addr_latch(ale), .chip_enable_n(ce_n),
        .write_strobe_n(we_n), .read_strobe_n(re_n), .write_protect_n(wp_n), .inj_fail(inj),
        .busy_cyc, .ready_busy_pin(rb), .dev_q(dq));
    task automatic end_sim;
        if (n_mismatch == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic cmp_q(input string w, input logic [7:0] e[$], input logic [7:0] g[$]);
        chk({w, " count"}, 16'(e.size()), 16'(g.size()));
        for (int i = 0; i < e.size() && i < g.size(); i++)
            chk(w, 16'(e[i]), 16'(g[i]));
    endtask
    // one user request, then compare with the reference
    task automatic do_op(input logic [2:0] c, input logic [12:0] len, input logic bad);
        int n;
        logic [7:0] ec[$];
        logic [7:0] ea[$];
        logic [7:0] ed[$];
        logic [7:0] es;
        logic [23:0] r;
        logic m;
        m = c[2:1] == 2'h1;
        i_ncmp_dev_model.cmd_log.delete();
        i_ncmp_dev_model.adr_log.delete();
        i_ncmp_dev_model.dat_log.delete();
        op_valid = 1'h1;
        op_code = c;
        op_len = len;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (op_ready !== 1'h1 && n < 50);
        #1 op_valid = 1'h0;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (op_done !== 1'h1 && n < 4000);
        chk("done", 16'h1, 16'(op_done));
        if (bad) begin
            chk("error", 16'h1, 16'(op_error));
            chk("cmds", 16'h0, 16'(i_ncmp_dev_model.cmd_log.size()));
            return;
        end
        if (m)
            ec = {`NCMP_CMD_LOAD, `NCMP_CMD_DUMMY, `NCMP_CMD_LOAD2};
        else if (c[2:1] == 2'h3)
            ec = {`NCMP_CMD_COPYLD};
        else if (!c[2])
            ec = {`NCMP_CMD_LOAD};
        if (c[2:1] != 2'h2) begin
            ec.push_back(c[0] ? `NCMP_CMD_FINAL : `NCMP_CMD_CACHE);
            t_pg = {t_pg[0], inj[0]};
            t_dist = inj;
            for (int p = 0; p <= int'(m); p++) begin
                r = p ? op_row_b : op_row_a;
                ea = {ea, op_col[7:0], op_col[15:8], r[7:0], r[15:8], r[23:16]};
                for (int i = 0; i < len; i++)
                    ed.push_back(mem[i]);
            end
        end
        ec.push_back(m || c == 3'h5 ? `NCMP_CMD_XSTATUS : `NCMP_CMD_STATUS);
        es = m || c == 3'h5 ? {3'h7, t_dist, |t_dist[1:0]} : {6'h38, t_pg};
        cmp_q("cmd", ec, i_ncmp_dev_model.cmd_log);
        cmp_q("addr", ea, i_ncmp_dev_model.adr_log);
        cmp_q("data", ed, i_ncmp_dev_model.dat_log);
        chk("status", 16'(es), 16'(stat_byte));
        chk("error", 16'(es[0] | es[1]), 16'(op_error));
    endtask
    // cut a hang short
    always @(posedge clock) begin
        cyc++;
        if (cyc == LIMIT) begin
            n_mismatch++;
            end_sim();
        end
    end
    initial begin
        logic [11:0] blk;
        logic [11:0] blk2;
        logic [5:0]  pg;
        void'($urandom(74));
        repeat (5) @(posedge clock);
        chk("reset pins", 16'({op_ready, ce_n, we_n, re_n, oe_n, wp_n}), 16'h001E);
        repeat (5) @(posedge clock);
        #1 rst_b = 1'h1;
        @(posedge clock);
        // load page data through the buffer port
        for (int i = 0; i < 16; i++) begin
            #1 buf_wr_en = 1'h1;
            buf_wr_addr = 13'(i);
            buf_wr_data = 8'($urandom);
            mem[i] = buf_wr_data;
            @(posedge clock);
        end
        #1 buf_wr_en = 1'h0;
        // every code three times, then three illegal pairs
        for (int k = 0; k < 27; k++) begin
            @(posedge clock);
            #1 blk = 12'($urandom);
            blk2 = 12'($urandom);
            pg = 6'($urandom);
            op_row_a = {6'h00, blk, pg};
            op_row_b = {6'h00, blk[11], blk2[10:1], ~blk[0], pg};
            if (k >= 24)
                op_row_b = op_row_a ^ (k == 24 ? 24'h000080 : k == 25 ? 24'h020040 : 24'h000041);
            inj = 4'($urandom);
            busy_cyc = 6'(1 + $urandom % 40);
            op_col = 16'($urandom);
            do_op(k < 24 ? 3'(k % 8) : 3'h2 + 3'(k % 2), 13'($urandom % 17), k >= 24);
        end
        end_sim();
    end
endmodule
`default_nettype wire
